// File: core/mcwd_pkg.sv
// Purpose: Constants for the motion configuration word decoder.
// Assumes: One 16-bit configuration word written by the network host.
// Notes:   Bit positions and function codes of the word.
package mcwd_pkg;
   localparam int WORD_W        = 16;
   localparam int MODE_BIT      = 15;
   localparam int NO_SMOOTH_BIT = 14;
   localparam int STALL_BIT     = 13;
   localparam int RSV_HI_BIT    = 12;
   localparam int PROX_BIT      = 11;
   localparam int ENC_BIT       = 10;
   localparam int IN2_LSB       = 3;
   localparam int IN1_LSB       = 0;
   localparam int FUNC_W        = 3;
   localparam logic [15:0] RSV_MASK   = 16'h13c0;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [15:0] ERR_STATUS = 16'h2000;
   localparam logic [2:0] FN_GP     = 3'h0;
   localparam logic [2:0] FN_CW     = 3'h1;
   localparam logic [2:0] FN_CCW    = 3'h2;
   localparam logic [2:0] FN_START  = 3'h3;
   localparam logic [2:0] FN_STOP   = 3'h4;
   localparam logic [2:0] FN_ESTOP  = 3'h5;
   localparam logic [2:0] FN_HOME   = 3'h6;
   localparam logic [2:0] FN_RSV    = 3'h7;
   localparam int SYNC_STAGES = 3;
endpackage

// File: core/mcwd_input_fn.sv
// Purpose: Synchronise one discrete input and derive its function events.
// Assumes: Pin is asynchronous; active level already applied outside.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/1ps
module mcwd_input_fn (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       pin,
   input  wire logic [2:0] func,
   output logic            level,
   output logic            rise,
   output logic            change
);
   logic s1;
   logic s2;
   logic s3;
   logic prev;
   logic prev_d;
   wire  agree      = (s2 == s3);
   wire  next_level = agree ? s3 : prev;
   // Edges are reported only for codes that act on them, so a general
   // purpose or limit input can never raise a stray event.
   wire  edge_fn    = (func == mcwd_pkg::FN_START)
                    | (func == mcwd_pkg::FN_STOP)
                    | (func == mcwd_pkg::FN_ESTOP)
                    | (func == mcwd_pkg::FN_HOME);
   wire  both_fn    = (func == mcwd_pkg::FN_START);

   // Only the second stage reads the first.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s1     <= 1'b0;
         s2     <= 1'b0;
         s3     <= 1'b0;
         prev   <= 1'b0;
         prev_d <= 1'b0;
      end else begin
         s1     <= pin;
         s2     <= s1;
         s3     <= s2;
         prev   <= next_level;
         prev_d <= prev;
      end
   end
   assign level  = prev;
   assign rise   = prev & ~prev_d & edge_fn;
   assign change = (prev ^ prev_d) & both_fn;
endmodule

// File: core/mcwd_top.sv
// Purpose: Decode configuration word 0 and route the two inputs.
// Assumes: Word arrives with a one-cycle write strobe; pins asynchronous.
// Notes:   All outputs are registered; events are one-cycle pulses.
`timescale 1ns/1ps
module mcwd_top (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        cfg_write,
   input  wire logic [15:0] cfg_word,
   input  wire logic        in1_pin,
   input  wire logic        in2_pin,
   input  wire logic        prox_flag,
   output logic             config_mode,
   output logic             smoothing_off,
   output logic             stall_check_en,
   output logic             prox_homing_en,
   output logic             encoder_en,
   output logic             config_error,
   output logic [15:0]      status_word,
   output logic             cw_limit,
   output logic             ccw_limit,
   output logic             start_move,
   output logic             stop_move,
   output logic             estop,
   output logic             home_event,
   output logic             encoder_latch,
   output logic [1:0]       gp_inputs
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] word;

   function automatic logic fn_is(input logic [15:0] w,
                                  input logic [2:0]  code);
      fn_is = (w[mcwd_pkg::IN2_LSB +: mcwd_pkg::FUNC_W] == code)
           || (w[mcwd_pkg::IN1_LSB +: mcwd_pkg::FUNC_W] == code);
   endfunction

   wire [2:0] f1 = cfg_word[mcwd_pkg::IN1_LSB +: mcwd_pkg::FUNC_W];
   wire [2:0] f2 = cfg_word[mcwd_pkg::IN2_LSB +: mcwd_pkg::FUNC_W];
   wire [2:0] fa = word[mcwd_pkg::IN1_LSB +: mcwd_pkg::FUNC_W];
   wire [2:0] fb = word[mcwd_pkg::IN2_LSB +: mcwd_pkg::FUNC_W];
   wire rsv_set  = |(cfg_word & mcwd_pkg::RSV_MASK);
   wire dup_fn   = (f1 == f2) && (f1 != mcwd_pkg::FN_GP);
   wire bad_code = fn_is(cfg_word, mcwd_pkg::FN_RSV);
   wire stall_ne = cfg_word[mcwd_pkg::STALL_BIT]
                 & ~cfg_word[mcwd_pkg::ENC_BIT];
   wire invalid  = rsv_set | dup_fn | bad_code | stall_ne;
   wire want_cfg = cfg_word[mcwd_pkg::MODE_BIT];
   wire accept   = cfg_write & ~invalid;

   ////////////////////////////////////////////////////////////////////////
   logic l1;
   logic l2;
   logic r1;
   logic r2;
   logic c1;
   logic c2;
   mcwd_input_fn u_in1 (
      .clock  (clock),
      .rst_b  (rst_b),
      .pin    (in1_pin),
      .func   (fa),
      .level  (l1),
      .rise   (r1),
      .change (c1)
   );
   mcwd_input_fn u_in2 (
      .clock  (clock),
      .rst_b  (rst_b),
      .pin    (in2_pin),
      .func   (fb),
      .level  (l2),
      .rise   (r2),
      .change (c2)
   );
   // Proximity flag is a pin as well; sync it the same way.
   logic p1;
   logic p2;
   logic p3;
   logic prox;
   wire  next_prox = (p2 == p3) ? p3 : prox;

   wire [1:0] lv   = {l2, l1};
   wire [1:0] rs   = {r2, r1};
   wire [1:0] ch   = {c2, c1};
   wire enc        = word[mcwd_pkg::ENC_BIT];
   // Level or edge of whichever input carries code c.
   function automatic logic sel(input logic [1:0] v, input logic [2:0] a,
                                input logic [2:0] b, input logic [2:0] c);
      sel = (v[0] && a == c) || (v[1] && b == c);
   endfunction
   wire next_cw    = sel(lv, fa, fb, mcwd_pkg::FN_CW);
   wire next_ccw   = sel(lv, fa, fb, mcwd_pkg::FN_CCW);
   wire next_start = sel(rs, fa, fb, mcwd_pkg::FN_START);
   wire next_stop  = sel(rs, fa, fb, mcwd_pkg::FN_STOP);
   wire next_estop = sel(rs, fa, fb, mcwd_pkg::FN_ESTOP);
   // A home edge without the flag is dropped when proximity homing is on.
   wire home_rise  = sel(rs, fa, fb, mcwd_pkg::FN_HOME);
   wire next_home  = home_rise
                   & (~word[mcwd_pkg::PROX_BIT] | prox);
   wire next_latch = enc & (sel(ch, fa, fb, mcwd_pkg::FN_START)
                          | next_stop);
   wire [1:0] next_gp = {lv[1] & (fb == mcwd_pkg::FN_GP),
                         lv[0] & (fa == mcwd_pkg::FN_GP)};

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         word         <= mcwd_pkg::WORD_RESET;
         config_mode  <= 1'b0;
         config_error <= 1'b0;
         status_word  <= mcwd_pkg::WORD_RESET;
      end else if (cfg_write) begin
         if (accept) begin
            word        <= cfg_word;
            config_mode <= want_cfg;
            status_word <= cfg_word;
         end else begin
            config_mode <= 1'b0;
            status_word <= mcwd_pkg::ERR_STATUS;
         end
         config_error <= invalid;
      end
   end

   // Mode bits are held at reset value until a word is accepted.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         smoothing_off  <= 1'b0;
         stall_check_en <= 1'b0;
         prox_homing_en <= 1'b0;
         encoder_en     <= 1'b0;
         p1             <= 1'b0;
         p2             <= 1'b0;
         p3             <= 1'b0;
         prox           <= 1'b0;
         cw_limit       <= 1'b0;
         ccw_limit      <= 1'b0;
         start_move     <= 1'b0;
         stop_move      <= 1'b0;
         estop          <= 1'b0;
         home_event     <= 1'b0;
         encoder_latch  <= 1'b0;
         gp_inputs      <= 2'h0;
      end else begin
         smoothing_off  <= word[mcwd_pkg::NO_SMOOTH_BIT];
         stall_check_en <= word[mcwd_pkg::STALL_BIT] & enc;
         prox_homing_en <= word[mcwd_pkg::PROX_BIT];
         encoder_en     <= enc;
         p1             <= prox_flag;
         p2             <= p1;
         p3             <= p2;
         prox           <= next_prox;
         cw_limit       <= next_cw;
         ccw_limit      <= next_ccw;
         start_move     <= next_start;
         stop_move      <= next_stop;
         estop          <= next_estop;
         home_event     <= next_home;
         encoder_latch  <= next_latch;
         gp_inputs      <= next_gp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_bad_word: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && invalid |=> config_error && !config_mode)
      else $error("invalid word not flagged");
   chk_bad_kept: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && invalid |=> word == $past(word))
      else $error("refused word was stored");
   chk_good_mirror: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && !invalid |=> status_word == $past(cfg_word))
      else $error("status does not mirror word");
   chk_mode_bit: assert property (
      @(posedge clock) disable iff (!rst_b)
      accept |=> config_mode == $past(cfg_word[mcwd_pkg::MODE_BIT]))
      else $error("mode bit not taken");
   chk_dup_fn: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && f1 == f2 && f1 != mcwd_pkg::FN_GP |=> config_error)
      else $error("duplicate function accepted");
   chk_rsv_bits: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && rsv_set |=> config_error)
      else $error("reserved bit accepted");
   chk_code_seven: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && fn_is(cfg_word, mcwd_pkg::FN_RSV) |=> config_error)
      else $error("reserved input code accepted");
   chk_smooth_off: assert property (
      @(posedge clock) disable iff (!rst_b)
      accept |=> ##1
         smoothing_off == $past(cfg_word[mcwd_pkg::NO_SMOOTH_BIT], 2))
      else $error("smoothing control wrong");
   chk_stall_enc: assert property (
      @(posedge clock) disable iff (!rst_b)
      cfg_write && cfg_word[mcwd_pkg::STALL_BIT]
         && !cfg_word[mcwd_pkg::ENC_BIT] |=> config_error)
      else $error("stall check without encoder");
   chk_home_prox: assert property (
      @(posedge clock) disable iff (!rst_b)
      home_event |-> !$past(word[mcwd_pkg::PROX_BIT]) || $past(prox))
      else $error("home taken without proximity");
   chk_gp_quiet: assert property (
      @(posedge clock) disable iff (!rst_b)
      word[5:0] == 6'h00 |=> !estop && !start_move && !home_event)
      else $error("general input drove a function");
   chk_limit_lvl: assert property (
      @(posedge clock) disable iff (!rst_b)
      lv[0] && fa == mcwd_pkg::FN_CW |=> cw_limit)
      else $error("clockwise limit not shown");
   chk_start_cap: assert property (
      @(posedge clock) disable iff (!rst_b)
      enc && ch[0] && fa == mcwd_pkg::FN_START |=> encoder_latch)
      else $error("start input change not captured");
   chk_stop_pulse: assert property (
      @(posedge clock) disable iff (!rst_b)
      rs[0] && fa == mcwd_pkg::FN_STOP |=> stop_move)
      else $error("stop input edge lost");
   chk_estop_edge: assert property (
      @(posedge clock) disable iff (!rst_b)
      rs[1] && fb == mcwd_pkg::FN_ESTOP |=> estop)
      else $error("emergency stop edge lost");
endmodule

// File: dv/mcwd_host.sv
// Purpose: Network host model that writes configuration word 0.
// Assumes: A write is a one-cycle strobe taken at a rising edge.
// Notes:   The word is scrambled once the strobe has gone.
`timescale 1ns/1ps
module mcwd_host (
   input  wire logic        clock,
   output logic             cfg_write,
   output logic [15:0]      cfg_word,
   output logic             prox_flag
);
   initial begin
      cfg_write = 1'b0;
      cfg_word  = 16'h0000;
      prox_flag = 1'b0;
   end
   // Reserved bits are set only where the bench wants a refusal.
   task automatic send(input logic [15:0] w);
      @(posedge clock);
      cfg_word  <= w;
      cfg_write <= 1'b1;
      @(posedge clock);
      cfg_write <= 1'b0;
      cfg_word  <= ~w;
   endtask
   task automatic prox(input logic v);
      @(posedge clock);
      prox_flag <= v;
   endtask
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the configuration word decoder.
// Assumes: Decoded outputs settle two edges after the write edge.
// Notes:   Event waits span twelve cycles to cover the pin synchroniser.
`timescale 1ns/1ps
module tb;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        in1_pin = 1'b0;
   logic        in2_pin = 1'b0;
   logic        cfg_write, prox_flag, config_mode, smoothing_off;
   logic        stall_check_en, prox_homing_en, encoder_en, config_error;
   logic        cw_limit, ccw_limit, start_move, stop_move, estop;
   logic        home_event, encoder_latch;
   logic [1:0]  gp_inputs;
   logic [15:0] cfg_word, status_word;
   int          fails = 0;
   int          cmp_count = 0;
   logic [15:0] bad [7] = '{16'h9000, 16'h8040, 16'h8200, 16'h8009,
                            16'h8007, 16'ha000, 16'h8036};
   wire  [8:0]  outs = {gp_inputs, encoder_latch, home_event, estop,
                        stop_move, start_move, ccw_limit, cw_limit};
   always #12.5 clock = ~clock;
   mcwd_host host (.clock, .cfg_write, .cfg_word, .prox_flag);
   mcwd_top dut (.clock, .rst_b, .cfg_write, .cfg_word, .in1_pin,
      .in2_pin, .prox_flag, .config_mode, .smoothing_off, .stall_check_en,
      .prox_homing_en, .encoder_en, .config_error, .status_word, .cw_limit,
      .ccw_limit, .start_move, .stop_move, .estop, .home_event,
      .encoder_latch, .gp_inputs);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [15:0] e,
                        input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic pins(input logic a, input logic b);
      @(posedge clock);
      in1_pin <= a;
      in2_pin <= b;
   endtask
   // Counts high cycles so a stuck pulse is caught as well as a lost one.
   task automatic watch(input string n, input int ia, input int ea,
                        input int ib, input int eb);
      logic [15:0] ca;
      logic [15:0] cb;
      ca = 16'h0000;
      cb = 16'h0000;
      repeat (12) begin
         @(posedge clock);
         #1;
         ca = ca + 16'(outs[ia]);
         cb = cb + 16'(outs[ib]);
      end
      check(n, 16'(ea), ca);
      check(n, 16'(eb), cb);
   endtask
   task automatic cfg(input logic [15:0] w, input logic ok);
      logic [15:0] e;
      logic [15:0] s;
      pins(1'b0, 1'b0);
      repeat (12) @(posedge clock);
      host.send(w);
      repeat (2) @(posedge clock);
      #1;
      e = ok ? 16'({w[15], w[14], w[13] & w[10], w[11], w[10], 1'b0})
             : 16'h0001;
      s = 16'({config_mode, smoothing_off, stall_check_en, prox_homing_en,
               encoder_en, config_error});
      check("status", ok ? w : mcwd_pkg::ERR_STATUS, status_word);
      check("flags", e, s);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_words;
      check("reset", 16'h0000, status_word | 16'(config_mode));
      cfg(16'hec33, 1'b1);
      cfg(16'h4400, 1'b1);
      cfg(16'h8000, 1'b1);
      foreach (bad[i]) cfg(bad[i], 1'b0);
   endtask
   task automatic t_events;
      cfg(16'h8413, 1'b1);
      pins(1'b1, 1'b0);
      watch("start", 2, 1, 6, 1);
      pins(1'b0, 1'b1);
      watch("start_fall", 2, 0, 6, 1);
      check("ccw", 16'h0002, 16'(outs[1:0]));
      cfg(16'h8826, 1'b1);
      pins(1'b1, 1'b0);
      watch("home_no_prox", 5, 0, 6, 0);
      pins(1'b0, 1'b0);
      host.prox(1'b1);
      repeat (8) @(posedge clock);
      pins(1'b1, 1'b0);
      watch("home", 5, 1, 3, 0);
      cfg(16'h8429, 1'b1);
      pins(1'b0, 1'b1);
      watch("estop", 4, 1, 6, 0);
      pins(1'b1, 1'b1);
      watch("cw", 4, 0, 2, 0);
      check("cw", 16'h0001, 16'(outs[1:0]));
      cfg(16'h8404, 1'b1);
      pins(1'b1, 1'b1);
      watch("stop", 3, 1, 6, 1);
      check("gp", 16'h0002, 16'(gp_inputs));
   endtask
   // A reset in mid-run must drop every decoded enable and event.
   task automatic t_reset;
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("reset_outs", 16'h0000, {config_mode, smoothing_off,
            stall_check_en, prox_homing_en, encoder_en, config_error,
            1'b0, outs});
      check("reset_status", 16'h0000, status_word);
      @(posedge clock);
      rst_b <= 1'b1;
      cfg(16'h8000, 1'b1);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1;
      t_words();
      t_events();
      t_reset();
      conclude();
   end
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule
